// ==== hdl/event_counter_encoder_trigger.sv ====
// Implementation choices: the address-and-strobe port and the register offsets.
`default_nettype none
// Behaviour
// - three counters, selector picks one, default zero
// - event source off, scan trigger, line, exposure
// - count only on event rising edge
// - clear source software or listed input line
// - line clear on rise, fall, high, low
// - 32-bit readable count, zero after reset
// - state codes idle through overflow; only idle, active and overflow are ever reported
// - phase inputs routable from off or lines
// - ratio division or edge skipping method
// - ratio gives 65536 over divisor triggers
// - skipping passes programmed edge count
// - trigger and direction selectable as outputs
// - trigger width 10 to 2550 ns
module event_counter_encoder_trigger (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic scan_trigger_event_i,
  input wire logic line_start_i,
  input wire logic exposure_start_i,
  input wire logic [5:0] lines_i,
  output logic rotary_trigger_out_o,
  output logic rotary_direction_out_o,
  output logic line_out_o,
  output logic irq_o
);
  // ****************************************
  // decoding helpers
  // ****************************************
  function automatic logic line_of(input logic [7:0] code, input logic [5:0] v);
    logic r;
    r = 1'b0;
    case (code)
      tally_pkg::LN_TTL1: r = v[0];
      tally_pkg::LN_OPT1: r = v[1];
      tally_pkg::LN_CXP: r = v[2];
      tally_pkg::LN_TTL2: r = v[3];
      tally_pkg::LN_TTL3: r = v[4];
      tally_pkg::LN_TTL4: r = v[5];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic code_ok(input logic [7:0] code, input logic cxp);
    logic r;
    r = 1'b0;
    case (code)
      tally_pkg::LN_SOFT, tally_pkg::LN_TTL1, tally_pkg::LN_OPT1,
      tally_pkg::LN_TTL2, tally_pkg::LN_TTL3, tally_pkg::LN_TTL4: r = 1'b1;
      tally_pkg::LN_CXP: r = cxp;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ****************************************
  // reset release and input synchronisers
  // ****************************************
  logic [1:0] rst_sq;
  logic rst_n;
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_sq <= 2'h0;
    else
      rst_sq <= {rst_sq[0], 1'b1};
  end
  assign rst_n = rst_sq[1];

  logic [5:0] ln_s1_q, ln_s2_q, ln_s3_q;
  logic [2:0] ev_prev_q;
  logic [2:0] ev_now, ev_rise;
  assign ev_now = {exposure_start_i, line_start_i, scan_trigger_event_i};
  assign ev_rise = ev_now & ~ev_prev_q;
  // s1 feeds s2 only; edges are taken between s2 and s3
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ln_s1_q <= 6'h00;
      ln_s2_q <= 6'h00;
      ln_s3_q <= 6'h00;
      ev_prev_q <= 3'h0;
    end
    else if (ce_i)
    begin
      ln_s1_q <= lines_i;
      ln_s2_q <= ln_s1_q;
      ln_s3_q <= ln_s2_q;
      ev_prev_q <= ev_now;
    end
  end

  // ****************************************
  // global registers
  // ****************************************
  logic [1:0] pick_q;
  logic [7:0] ph_a_q, ph_b_q, lsrc_q, wid_q;
  logic method_q;
  logic [31:0] div_q;
  logic [15:0] skip_cnt_q;
  logic [3:0] imask_q;
  logic wr_en;
  assign wr_en = ce_i && wr_i;
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pick_q <= 2'h0;
      ph_a_q <= tally_pkg::LN_SOFT;
      ph_b_q <= tally_pkg::LN_SOFT;
      method_q <= tally_pkg::M_RATIO;
      div_q <= tally_pkg::DIV_RST;
      skip_cnt_q <= tally_pkg::SKIP_RST;
      wid_q <= tally_pkg::WIDTH_RST;
      lsrc_q <= 8'h00;
      imask_q <= 4'h0;
    end
    else if (wr_en)
    begin
      case (addr_i)
        tally_pkg::OFS_PICK:
          if (wdata_i[1:0] <= tally_pkg::PICK_MAX && wdata_i[31:2] == 30'h0)
            pick_q <= wdata_i[1:0];
        tally_pkg::OFS_PH_A:
          if (code_ok(wdata_i[7:0], 1'b0))
            ph_a_q <= wdata_i[7:0];
        tally_pkg::OFS_PH_B:
          if (code_ok(wdata_i[7:0], 1'b0))
            ph_b_q <= wdata_i[7:0];
        tally_pkg::OFS_METHOD: method_q <= wdata_i[0];
        tally_pkg::OFS_DIV:
          if (wdata_i != 32'h0)
            div_q <= wdata_i;
        tally_pkg::OFS_SKIP: skip_cnt_q <= wdata_i[15:0];
        tally_pkg::OFS_WIDTH:
          if (wdata_i[7:0] != 8'h00)
            wid_q <= wdata_i[7:0];
        tally_pkg::OFS_LSRC: lsrc_q <= wdata_i[7:0];
        tally_pkg::OFS_IMASK: imask_q <= wdata_i[3:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // counters
  // ****************************************
  logic [31:0] cnt_q [3];
  logic [1:0] eo_a [3];
  logic [7:0] co_a [3];
  logic [2:0] cc_a [3];
  logic [2:0] st_a [3];
  logic [2:0] ovf_ev, hit_a, inc_a;
  logic sw_clr;
  assign sw_clr = wr_en && addr_i == tally_pkg::OFS_CLR_CMD;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_tally
      logic sel, lv, lp, ovf_q;
      assign sel = pick_q == 2'(gi);
      assign lv = line_of(co_a[gi], ln_s2_q);
      assign lp = line_of(co_a[gi], ln_s3_q);
      always_ff @(posedge mclk_i or negedge rst_n)
      begin
        if (!rst_n)
        begin
          eo_a[gi] <= tally_pkg::EV_OFF;
          co_a[gi] <= tally_pkg::LN_SOFT;
          cc_a[gi] <= tally_pkg::CL_RISE;
        end
        else if (wr_en && sel)
        begin
          if (addr_i == tally_pkg::OFS_EVT)
            eo_a[gi] <= wdata_i[1:0];
          if (addr_i == tally_pkg::OFS_CLR_ORG && code_ok(wdata_i[7:0], 1'b1))
            co_a[gi] <= wdata_i[7:0];
          if (addr_i == tally_pkg::OFS_CLR_CND && wdata_i[2:0] >= tally_pkg::CL_RISE
              && wdata_i[2:0] <= tally_pkg::CL_LOW)
            cc_a[gi] <= wdata_i[2:0];
        end
      end
      always_comb
      begin
        hit_a[gi] = 1'b0;
        if (co_a[gi] == tally_pkg::LN_SOFT)
          hit_a[gi] = sw_clr && sel;
        else
        begin
          case (cc_a[gi])
            tally_pkg::CL_RISE: hit_a[gi] = lv && !lp;
            tally_pkg::CL_FALL: hit_a[gi] = !lv && lp;
            tally_pkg::CL_HIGH: hit_a[gi] = lv;
            tally_pkg::CL_LOW: hit_a[gi] = !lv;
            default: hit_a[gi] = 1'b0;
          endcase
        end
      end
      // off selects nothing, so no edge can reach the counter
      assign inc_a[gi] = eo_a[gi] != tally_pkg::EV_OFF && ev_rise[eo_a[gi] - 2'h1];
      // a clear in the same cycle wins, so no overflow is reported then
      assign ovf_ev[gi] = inc_a[gi] && !hit_a[gi] && cnt_q[gi] == 32'hFFFF_FFFF;
      always_ff @(posedge mclk_i or negedge rst_n)
      begin
        if (!rst_n)
        begin
          cnt_q[gi] <= 32'h0000_0000;
          ovf_q <= 1'b0;
        end
        else if (ce_i)
        begin
          if (hit_a[gi])
          begin
            cnt_q[gi] <= 32'h0000_0000;
            ovf_q <= 1'b0;
          end
          else if (inc_a[gi])
          begin
            cnt_q[gi] <= cnt_q[gi] + 32'h0000_0001;
            if (ovf_ev[gi])
              ovf_q <= 1'b1;
          end
        end
      end
      always_comb
      begin
        if (ovf_q)
          st_a[gi] = tally_pkg::ST_OVER;
        else if (eo_a[gi] == tally_pkg::EV_OFF)
          st_a[gi] = tally_pkg::ST_IDLE;
        else
          st_a[gi] = tally_pkg::ST_ACTIVE;
      end
    end
  endgenerate

  // ****************************************
  // encoder trigger
  // ****************************************
  logic pa, pa_p, pb, pb_p, a_rise, edge_any, fire, fire_r, fire_s;
  logic dir_q, trig_q, aux_q;
  logic [47:0] acc_q, acc_sum;
  logic [15:0] skip_q;
  logic [11:0] pw_q, pw_len;
  assign pa = line_of(ph_a_q, ln_s2_q);
  assign pa_p = line_of(ph_a_q, ln_s3_q);
  assign pb = line_of(ph_b_q, ln_s2_q);
  assign pb_p = line_of(ph_b_q, ln_s3_q);
  assign a_rise = pa && !pa_p;
  assign edge_any = (pa ^ pa_p) || (pb ^ pb_p);
  // several triggers per pulse leave one per cycle; a very small
  // divisor with very fast pulses lets the accumulator grow
  assign acc_sum = acc_q + (a_rise ? tally_pkg::RATIO_UNIT : 48'h0);
  assign fire_r = acc_sum >= {16'h0000, div_q};
  assign fire_s = edge_any && skip_q == skip_cnt_q;
  assign fire = method_q == tally_pkg::M_SKIP ? fire_s : fire_r;
  assign pw_len = 12'(wid_q) * 12'(tally_pkg::STEP_CYC);

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_q <= 48'h0;
      skip_q <= 16'h0000;
      dir_q <= 1'b0;
    end
    else if (ce_i)
    begin
      acc_q <= fire_r ? acc_sum - {16'h0000, div_q} : acc_sum;
      if (edge_any)
        skip_q <= fire_s ? 16'h0000 : skip_q + 16'h0001;
      if (a_rise)
        dir_q <= !pb;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pw_q <= 12'h000;
      trig_q <= 1'b0;
      aux_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (fire)
      begin
        pw_q <= pw_len - 12'h001;
        trig_q <= 1'b1;
      end
      else if (pw_q != 12'h000)
      begin
        pw_q <= pw_q - 12'h001;
        trig_q <= 1'b1;
      end
      else
        trig_q <= 1'b0;
      if (lsrc_q == tally_pkg::SRC_TRIG)
        aux_q <= trig_q;
      else if (lsrc_q == tally_pkg::SRC_DIR)
        aux_q <= dir_q;
      else
        aux_q <= 1'b0;
    end
  end
  assign rotary_trigger_out_o = trig_q;
  assign rotary_direction_out_o = dir_q;
  assign line_out_o = aux_q;

  // ****************************************
  // interrupts and readback
  // ****************************************
  logic [3:0] ist_q, ist_clr;
  logic irq_q;
  logic [31:0] rdata_q;
  assign ist_clr = (wr_en && addr_i == tally_pkg::OFS_ISTAT) ? wdata_i[3:0] : 4'h0;
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ist_q <= 4'h0;
      irq_q <= 1'b0;
    end
    else if (ce_i)
    begin
      // a new event in the clearing cycle survives the clear
      ist_q <= (ist_q & ~ist_clr) | {fire, ovf_ev};
      irq_q <= |(ist_q & imask_q);
    end
  end
  assign irq_o = irq_q;

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 32'h0000_0000;
    else if (ce_i)
    begin
      rdata_q <= 32'h0000_0000;
      if (rd_i)
      begin
        case (addr_i)
          tally_pkg::OFS_PICK: rdata_q <= {30'h0, pick_q};
          tally_pkg::OFS_EVT: rdata_q <= {30'h0, eo_a[pick_q]};
          tally_pkg::OFS_CLR_ORG: rdata_q <= {24'h0, co_a[pick_q]};
          tally_pkg::OFS_CLR_CND: rdata_q <= {29'h0, cc_a[pick_q]};
          tally_pkg::OFS_COUNT: rdata_q <= cnt_q[pick_q];
          tally_pkg::OFS_STATE: rdata_q <= {29'h0, st_a[pick_q]};
          tally_pkg::OFS_EDGE: rdata_q <= {29'h0, tally_pkg::EDGE_KIND};
          tally_pkg::OFS_PH_A: rdata_q <= {24'h0, ph_a_q};
          tally_pkg::OFS_PH_B: rdata_q <= {24'h0, ph_b_q};
          tally_pkg::OFS_METHOD: rdata_q <= {31'h0, method_q};
          tally_pkg::OFS_DIV: rdata_q <= div_q;
          tally_pkg::OFS_SKIP: rdata_q <= {16'h0, skip_cnt_q};
          tally_pkg::OFS_WIDTH: rdata_q <= {24'h0, wid_q};
          tally_pkg::OFS_LSRC: rdata_q <= {24'h0, lsrc_q};
          tally_pkg::OFS_ISTAT: rdata_q <= {28'h0, ist_q};
          tally_pkg::OFS_IMASK: rdata_q <= {28'h0, imask_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign rdata_o = rdata_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n);

  sequence s_sw_clear0;
    sw_clr && pick_q == 2'h0 && co_a[0] == tally_pkg::LN_SOFT;
  endsequence
  sequence s_fire_go;
    ce_i && fire;
  endsequence

  a_soft_clear_zero: assert property (s_sw_clear0 |=> cnt_q[0] == 32'h0)
    else $error("software clear did not zero counter");
  a_line_no_soft: assert property (
    sw_clr && co_a[0] != tally_pkg::LN_SOFT && !hit_a[0] && !inc_a[0] && ce_i
    |=> cnt_q[0] == $past(cnt_q[0]))
    else $error("software clear acted on line-cleared counter");
  a_off_frozen: assert property (
    eo_a[2] == tally_pkg::EV_OFF && !hit_a[2] |=> cnt_q[2] == $past(cnt_q[2]))
    else $error("counter moved while event off");
  a_count_step: assert property (
    ce_i && inc_a[0] && !hit_a[0] |=> cnt_q[0] == $past(cnt_q[0]) + 32'h1)
    else $error("counter did not step by one");
  a_level_hold: assert property (
    ce_i && cc_a[0] == tally_pkg::CL_HIGH && co_a[0] != tally_pkg::LN_SOFT
    && line_of(co_a[0], ln_s2_q) |=> cnt_q[0] == 32'h0)
    else $error("level clear did not hold zero");
  a_ovf_state: assert property (
    ce_i && ovf_ev[0] && !hit_a[0] |=> st_a[0] == tally_pkg::ST_OVER && cnt_q[0] == 32'h0)
    else $error("overflow not reported");
  a_read_count: assert property (
    ce_i && rd_i && addr_i == tally_pkg::OFS_COUNT |=> rdata_o == $past(cnt_q[pick_q]))
    else $error("count readback wrong");
  a_pulse_start: assert property (s_fire_go |=> trig_q ##0 pw_q == $past(pw_len) - 12'h1)
    else $error("trigger pulse did not start");
  a_pulse_end: assert property (
    ce_i && !fire && pw_q == 12'h0 |=> !trig_q)
    else $error("trigger pulse too long");
  a_skip_fire: assert property (
    ce_i && method_q == tally_pkg::M_SKIP && edge_any && skip_q == skip_cnt_q
    |=> trig_q && skip_q == 16'h0)
    else $error("edge skip trigger missing");
  a_ratio_fire: assert property (
    ce_i && method_q == tally_pkg::M_RATIO && a_rise && div_q == tally_pkg::DIV_RST
    && acc_q == 48'h0 |=> trig_q && acc_q == 48'h0)
    else $error("unit divisor did not give one trigger");
  a_dir_route: assert property (
    ce_i && lsrc_q == tally_pkg::SRC_DIR |=> line_out_o == $past(dir_q))
    else $error("direction not routed to line");
endmodule
`default_nettype wire

// ==== hdl/tally_pkg.sv ====
`default_nettype none
package tally_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_PICK = 8'h00;
  localparam logic [7:0] OFS_EVT = 8'h04;
  localparam logic [7:0] OFS_CLR_ORG = 8'h08;
  localparam logic [7:0] OFS_CLR_CND = 8'h0C;
  localparam logic [7:0] OFS_CLR_CMD = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;
  localparam logic [7:0] OFS_EDGE = 8'h1C;
  localparam logic [7:0] OFS_PH_A = 8'h20;
  localparam logic [7:0] OFS_PH_B = 8'h24;
  localparam logic [7:0] OFS_METHOD = 8'h28;
  localparam logic [7:0] OFS_DIV = 8'h2C;
  localparam logic [7:0] OFS_SKIP = 8'h30;
  localparam logic [7:0] OFS_WIDTH = 8'h34;
  localparam logic [7:0] OFS_LSRC = 8'h38;
  localparam logic [7:0] OFS_ISTAT = 8'h3C;
  localparam logic [7:0] OFS_IMASK = 8'h40;
  // ****************************************
  // codes and reset values
  // ****************************************
  localparam logic [1:0] EV_OFF = 2'h0;
  localparam logic [7:0] LN_SOFT = 8'h00;
  localparam logic [7:0] LN_TTL1 = 8'h17;
  localparam logic [7:0] LN_OPT1 = 8'h18;
  localparam logic [7:0] LN_CXP = 8'h1A;
  localparam logic [7:0] LN_TTL2 = 8'h1D;
  localparam logic [7:0] LN_TTL3 = 8'h20;
  localparam logic [7:0] LN_TTL4 = 8'h21;
  localparam logic [7:0] SRC_TRIG = 8'h26;
  localparam logic [7:0] SRC_DIR = 8'h27;
  localparam logic [2:0] CL_RISE = 3'h1;
  localparam logic [2:0] CL_FALL = 3'h2;
  localparam logic [2:0] CL_HIGH = 3'h3;
  localparam logic [2:0] CL_LOW = 3'h4;
  localparam logic [2:0] EDGE_KIND = 3'h1;
  localparam logic [1:0] PICK_MAX = 2'h2;
  localparam logic [47:0] RATIO_UNIT = 48'h0000_0001_0000;
  localparam logic [31:0] DIV_RST = 32'h0001_0000;
  localparam logic [15:0] SKIP_RST = 16'h0000;
  localparam logic [7:0] WIDTH_RST = 8'h01;
  localparam int CLK_NS = 10;
  localparam int STEP_NS = 10;
  localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_WAIT = 3'b001, ST_ACTIVE = 3'b010,
    ST_DONE = 3'b011, ST_OVER = 3'b100
  } tally_state_e;
  typedef enum logic {M_RATIO = 1'b0, M_SKIP = 1'b1} method_e;
endpackage
`default_nettype wire

// ==== verification/rotary_line_model.sv ====
`default_nettype none
// ****************************************
// encoder and clear-line partner
// ****************************************
module rotary_line_model (
  input wire logic mclk_i,
  output logic [5:0] lines_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial lines_o = 6'h00;

  // lines are driven right after an edge and held for gap cycles
  task automatic set_line(input int idx, input logic lvl, input int gap);
    @(posedge mclk_i);
    lines_o[idx] <= lvl;
    repeat (gap) @(posedge mclk_i);
  endtask

  // quadrature step: phase a on bit0, phase b on bit1; a leads going forward
  task automatic step(input logic fwd, input int gap);
    logic [1:0] ab;
    ab = lines_o[1:0];
    @(posedge mclk_i);
    if ((ab[0] == ab[1]) == fwd)
      lines_o[0] <= ~ab[0];
    else
      lines_o[1] <= ~ab[1];
    repeat (gap) @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire

// ==== verification/test_event_counter_encoder_trigger.sv ====
`default_nettype none
module test_event_counter_encoder_trigger;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [2:0] ev = 3'h0;
  logic [31:0] rdata_o;
  logic [5:0] lines_i;
  logic trig_o, dir_o, line_out_o, irq_o;
  logic trig_q = 1'b0;
  logic out_q = 1'b0;
  int num_errors = 0;
  int tests_run = 0;
  int trig_rises = 0;
  int out_rises = 0;
  int run_len = 0;
  int run_max = 0;

  always #5 mclk_i = ~mclk_i;

  event_counter_encoder_trigger u_dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(1'b1), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .scan_trigger_event_i(ev[0]), .line_start_i(ev[1]), .exposure_start_i(ev[2]),
    .lines_i(lines_i), .rotary_trigger_out_o(trig_o), .rotary_direction_out_o(dir_o),
    .line_out_o(line_out_o), .irq_o(irq_o)
  );

  rotary_line_model u_lines (.mclk_i(mclk_i), .lines_o(lines_i));

  // pulse counting on the trigger pin and the routed output line
  always @(posedge mclk_i)
  begin
    trig_q <= trig_o;
    out_q <= line_out_o;
    if (trig_o === 1'b1 && trig_q !== 1'b1)
      trig_rises++;
    if (line_out_o === 1'b1 && out_q !== 1'b1)
      out_rises++;
    if (trig_o === 1'b1)
      run_len++;
    else
      run_len = 0;
    if (run_len > run_max)
      run_max = run_len;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    check(what, exp, rdata_o);
  endtask

  task automatic pulse(input int which, input int n);
    repeat (n)
    begin
      @(posedge mclk_i);
      ev[which] <= 1'b1;
      @(posedge mclk_i);
      ev[which] <= 1'b0;
    end
    repeat (2) @(posedge mclk_i);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_defaults();
    rd_chk("pick", tally_pkg::OFS_PICK, 32'h0);
    rd_chk("event origin", tally_pkg::OFS_EVT, 32'h0);
    rd_chk("clear origin", tally_pkg::OFS_CLR_ORG, 32'h0);
    rd_chk("clear cond", tally_pkg::OFS_CLR_CND, 32'h1);
    rd_chk("edge kind", tally_pkg::OFS_EDGE, 32'h1);
    rd_chk("state", tally_pkg::OFS_STATE, 32'h0);
    rd_chk("phase a", tally_pkg::OFS_PH_A, 32'h0);
    rd_chk("method", tally_pkg::OFS_METHOD, 32'h0);
    rd_chk("divisor", tally_pkg::OFS_DIV, 32'h0001_0000);
    rd_chk("skip", tally_pkg::OFS_SKIP, 32'h0);
    rd_chk("width", tally_pkg::OFS_WIDTH, 32'h1);
    bus_wr(tally_pkg::OFS_COUNT, 32'h5);
    rd_chk("count", tally_pkg::OFS_COUNT, 32'h0);
    rd_chk("unmapped", 8'hFC, 32'h0);
    $display("test defaults done");
  endtask

  task automatic t_counting();
    pulse(0, 1);
    rd_chk("count off", tally_pkg::OFS_COUNT, 32'h0);
    bus_wr(tally_pkg::OFS_EVT, 32'h1);
    pulse(0, 3);
    @(posedge mclk_i);
    ev[0] <= 1'b1;
    repeat (6) @(posedge mclk_i);
    ev[0] <= 1'b0;
    rd_chk("count0", tally_pkg::OFS_COUNT, 32'h4);
    rd_chk("state0", tally_pkg::OFS_STATE, 32'h2);
    bus_wr(tally_pkg::OFS_PICK, 32'h1);
    bus_wr(tally_pkg::OFS_EVT, 32'h2);
    pulse(1, 2);
    pulse(0, 1);
    rd_chk("count1", tally_pkg::OFS_COUNT, 32'h2);
    bus_wr(tally_pkg::OFS_PICK, 32'h2);
    bus_wr(tally_pkg::OFS_EVT, 32'h3);
    pulse(2, 1);
    bus_wr(tally_pkg::OFS_PICK, 32'h3);
    rd_chk("pick", tally_pkg::OFS_PICK, 32'h2);
    rd_chk("count2", tally_pkg::OFS_COUNT, 32'h1);
    bus_wr(tally_pkg::OFS_PICK, 32'h0);
    rd_chk("count0 kept", tally_pkg::OFS_COUNT, 32'h5);
    bus_wr(tally_pkg::OFS_CLR_CMD, 32'h1);
    rd_chk("soft clear", tally_pkg::OFS_COUNT, 32'h0);
    $display("test counting done");
  endtask

  task automatic t_line_clear();
    int bit_i[4] = '{0, 2, 3, 5};
    logic [7:0] code[4] = '{tally_pkg::LN_TTL1, tally_pkg::LN_CXP, tally_pkg::LN_TTL2,
      tally_pkg::LN_TTL4};
    logic [2:0] cnd[4] = '{tally_pkg::CL_RISE, tally_pkg::CL_HIGH, tally_pkg::CL_FALL,
      tally_pkg::CL_LOW};
    logic pre[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic post[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    logic [31:0] ea[4] = '{32'h2, 32'h3, 32'h2, 32'h2};
    logic [31:0] eb[4] = '{32'h1, 32'h0, 32'h1, 32'h0};
    for (int i = 0; i < 4; i++)
    begin
      bus_wr(tally_pkg::OFS_CLR_ORG, {24'h0, code[i]});
      bus_wr(tally_pkg::OFS_CLR_CND, {29'h0, cnd[i]});
      u_lines.set_line(bit_i[i], pre[i], 4);
      pulse(0, 2);
      bus_wr(tally_pkg::OFS_CLR_CMD, 32'h1);
      rd_chk("before clear", tally_pkg::OFS_COUNT, ea[i]);
      u_lines.set_line(bit_i[i], ~pre[i], 4);
      rd_chk("line clear", tally_pkg::OFS_COUNT, 32'h0);
      pulse(0, 1);
      rd_chk("after clear", tally_pkg::OFS_COUNT, eb[i]);
      u_lines.set_line(bit_i[i], post[i], 4);
    end
    bus_wr(tally_pkg::OFS_CLR_ORG, 32'h0);
    pulse(0, 1);
    u_lines.set_line(0, 1'b1, 4);
    u_lines.set_line(0, 1'b0, 4);
    rd_chk("line ignored", tally_pkg::OFS_COUNT, 32'h1);
    $display("test line clear done");
  endtask

  task automatic t_encoder();
    bus_wr(tally_pkg::OFS_PH_A, {24'h0, tally_pkg::LN_TTL1});
    bus_wr(tally_pkg::OFS_PH_B, {24'h0, tally_pkg::LN_OPT1});
    bus_wr(tally_pkg::OFS_LSRC, {24'h0, tally_pkg::SRC_TRIG});
    bus_wr(tally_pkg::OFS_DIV, 32'h0002_0000);
    trig_rises = 0;
    out_rises = 0;
    repeat (16) u_lines.step(1'b1, 3);
    repeat (6) @(posedge mclk_i);
    check("ratio triggers", 32'(trig_rises), 32'h2);
    check("line out triggers", 32'(out_rises), 32'h2);
    check("width one", 32'(run_max), 32'h1);
    bus_wr(tally_pkg::OFS_DIV, 32'h0001_0000);
    trig_rises = 0;
    repeat (4) u_lines.step(1'b1, 3);
    repeat (6) @(posedge mclk_i);
    check("ratio unit", 32'(trig_rises), 32'h1);
    bus_wr(tally_pkg::OFS_METHOD, 32'h1);
    bus_wr(tally_pkg::OFS_SKIP, 32'h2);
    bus_wr(tally_pkg::OFS_WIDTH, 32'h3);
    trig_rises = 0;
    repeat (12) u_lines.step(1'b1, 4);
    repeat (6) @(posedge mclk_i);
    check("skip triggers", 32'(trig_rises), 32'h4);
    check("width three", 32'(run_max), 32'h3);
    bus_wr(tally_pkg::OFS_LSRC, {24'h0, tally_pkg::SRC_DIR});
    repeat (4) u_lines.step(1'b0, 4);
    check("reverse", {dir_o, line_out_o}, 32'h0);
    repeat (4) u_lines.step(1'b1, 4);
    check("forward", {dir_o, line_out_o}, 32'h3);
    rd_chk("irq status", tally_pkg::OFS_ISTAT, 32'h8);
    check("irq masked", irq_o, 32'h0);
    bus_wr(tally_pkg::OFS_IMASK, 32'h8);
    repeat (3) @(posedge mclk_i);
    check("irq raised", irq_o, 32'h1);
    bus_wr(tally_pkg::OFS_ISTAT, 32'h8);
    repeat (3) @(posedge mclk_i);
    check("irq cleared", irq_o, 32'h0);
    rd_chk("status cleared", tally_pkg::OFS_ISTAT, 32'h0);
    $display("test encoder done");
  endtask

  initial
  begin
    #100us;
    num_errors++;
    $display("MISMATCH watchdog expected finish seen timeout");
    complete_run();
  end

  initial
  begin
    repeat (2) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    t_defaults();
    t_counting();
    t_line_clear();
    t_encoder();
    complete_run();
  end
endmodule
`default_nettype wire
